// [timer_defs.sv]
// Package for the 8-bit timer with shared prescaler.
// Assumes one 20 MHz clock, synchronous active-high reset, AHB-Lite host.
// Operation
// - Timer mode counts once per instruction cycle (clock divided by four).
// - Writing the count suppresses counting for two instruction cycles.
// - Counter mode counts edges of the external count input.
// - Edge select one counts falling edges, zero counts rising edges.
// - One prescaler serves either the timer or the watchdog, never both.
// - Timer prescale divides by two to the power of rate plus one.
// - Watchdog prescale spans 1:1 to 1:128; timer then runs undivided.
// - Prescaler count is hidden; count writes clear it when timer-owned.
// - Watchdog clear also clears the prescaler while watchdog-owned.
// - Wrap from FFh to 00h sets the flag; interrupt needs enable.
// - Sleep freezes the count, so no overflow occurs.
// - Counter mode samples prescaler output on phase two and four.
`default_nettype none

package timer_defs;
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_INTCTL = 8'h08;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam int INTCTL_EN_BIT = 5;
  localparam int INTCTL_FLAG_BIT = 2;
  localparam int INSTR_CLOCKS = 4;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLOCKS = 4'(INSTR_CLOCKS * INHIBIT_INSTR);
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef struct packed {
    logic pullup_off;
    logic int_edge;
    logic src_sel;
    logic edge_sel;
    logic assign_wdt;
    logic [2:0] rate;
  } option_t;

  typedef enum logic [1:0] {
    REG_OPTION = 2'b00,
    REG_COUNT = 2'b01,
    REG_INTCTL = 2'b10,
    REG_NONE = 2'b11
  } reg_sel_t;
endpackage

`default_nettype wire

// [prescaler_core.sv]
// Shared power-of-two prescaler with hidden count.
// Assumes tick and clear are one-cycle pulses in the clock domain.
`timescale 1ns/1ps
`default_nettype none

module prescaler_core #(
  parameter int COUNT_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] rate,
  input wire logic timer_owned,
  output logic tc
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] limit;

  // Rate 7 with the extra timer shift needs eight bits
  if (COUNT_W < 8) begin : g_check
    $error("prescaler_core needs COUNT_W of at least 8");
  end

  // Terminal value for a ratio of 2**(rate+shift)
  function automatic logic [COUNT_W-1:0] term(input logic [2:0] r,
                                             input logic sh);
    logic [8:0] one;
    one = 9'h001;
    // Four-bit shift amount so rate 7 plus the timer shift reaches 8
    term = COUNT_W'((one << (4'(r) + 4'(sh))) - 9'h001);
  endfunction

  assign limit = term(rate, timer_owned);
  assign tc = tick && !clear && (count == limit);

  // Hidden count, cleared on demand
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      count <= '0;
    end else if (tick) begin
      count <= (count == limit) ? '0 : count + 1'b1;
    end
  end

  prescale_clear_a: assert property (@(posedge clock) disable iff (rst)
    clear |=> count == '0) else $error("prescaler not cleared");
  terminal_count_a: assert property (@(posedge clock) disable iff (rst)
    tc |-> count == limit && tick) else $error("early terminal");
endmodule // prescaler_core

`default_nettype wire

// [timer8.sv]
// Top of the 8-bit timer/counter with AHB-Lite register slave.
// Assumes synchronous pins, a single AHB master and zero-wait answers.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module timer8 (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic external_count_input,
  input wire logic sleep_mode,
  input wire logic watchdog_clear,
  input wire logic watchdog_tick,
  output logic watchdog_prescaled_tick,
  output logic overflow_irq
);
  timer_defs::option_t option_cfg;
  logic [7:0] count_register;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] phase;
  logic ext_prev;
  logic [3:0] inhibit;
  logic pending;
  logic wr_pend;
  timer_defs::reg_sel_t wr_sel;
  logic addr_take;
  logic wr_count;
  logic wr_option;
  logic wr_intctl;
  logic instr_tick;
  logic ext_edge;
  logic src_pulse;
  logic presc_tick;
  logic presc_clear;
  logic presc_tc;
  logic count_event;
  logic cnt_inc;
  logic sample_phase;
  logic unused_bits;

  // Map a byte address onto a register
  function automatic timer_defs::reg_sel_t decode(input logic [31:0] a);
    if (a[31:8] != '0) begin
      decode = timer_defs::REG_NONE;
    end else begin
      case (a[7:0])
        timer_defs::OFS_OPTION: decode = timer_defs::REG_OPTION;
        timer_defs::OFS_COUNT: decode = timer_defs::REG_COUNT;
        timer_defs::OFS_INTCTL: decode = timer_defs::REG_INTCTL;
        default: decode = timer_defs::REG_NONE;
      endcase
    end
  endfunction

  // Read view of a register, reserved bits zero
  function automatic logic [7:0] read_view(input timer_defs::reg_sel_t s,
                                           input timer_defs::option_t o,
                                           input logic [7:0] c,
                                           input logic en,
                                           input logic fl);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      timer_defs::REG_OPTION: v = o;
      timer_defs::REG_COUNT: v = c;
      timer_defs::REG_INTCTL: begin
        v[timer_defs::INTCTL_EN_BIT] = en;
        v[timer_defs::INTCTL_FLAG_BIT] = fl;
      end
      default: v = 8'h00;
    endcase
    read_view = v;
  endfunction

  // Bus decode and write strobes in the data phase
  assign addr_take = hsel && hready && (htrans == timer_defs::HTRANS_NONSEQ_BIT
                     || htrans == 2'h3);
  assign wr_count = wr_pend && wr_sel == timer_defs::REG_COUNT;
  assign wr_option = wr_pend && wr_sel == timer_defs::REG_OPTION;
  assign wr_intctl = wr_pend && wr_sel == timer_defs::REG_INTCTL;
  assign unused_bits = ^{hsize, hwdata[31:8]};

  // Address phase capture; writes land one cycle later
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_sel <= timer_defs::REG_NONE;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_sel <= decode(haddr);
    end
  end

  // Zero-wait, always OKAY slave answers
  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_take && !hwrite) begin
        hrdata <= {24'h000000, read_view(decode(haddr), option_cfg,
                   count_register, overflow_irq_enable, overflow_flag)};
      end
    end
  end

  // Option register
  always_ff @(posedge clock) begin
    if (rst) begin
      option_cfg <= timer_defs::OPTION_RESET;
    end else if (wr_option) begin
      option_cfg <= hwdata[7:0];
    end
  end

  // Phase clock: four clocks make one instruction cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign instr_tick = phase == timer_defs::PHASE_FOUR;
  assign sample_phase = phase == timer_defs::PHASE_TWO
                        || phase == timer_defs::PHASE_FOUR;

  // Pin history for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= external_count_input;
    end
  end

  // Counting edge on the pin, polarity by edge select
  assign ext_edge = option_cfg.edge_sel
                    ? (ext_prev && !external_count_input)
                    : (!ext_prev && external_count_input);
  assign src_pulse = (option_cfg.src_sel ? ext_edge : instr_tick)
                     && !sleep_mode;

  // Prescaler ownership steers its tick and clear
  assign presc_tick = option_cfg.assign_wdt ? watchdog_tick
                      : src_pulse;
  assign presc_clear = option_cfg.assign_wdt ? watchdog_clear
                       : wr_count;

  prescaler_core #(
    .COUNT_W(8)
  ) u_presc (
    .clock(clock),
    .rst(rst),
    .tick(presc_tick),
    .clear(presc_clear),
    .rate(option_cfg.rate),
    .timer_owned(!option_cfg.assign_wdt),
    .tc(presc_tc)
  );

  // Watchdog takes the divided tick only when it owns the prescaler
  always_ff @(posedge clock) begin
    if (rst) begin
      watchdog_prescaled_tick <= 1'b0;
    end else begin
      watchdog_prescaled_tick <= presc_tc && option_cfg.assign_wdt;
    end
  end

  // Undivided source when the watchdog owns the prescaler
  assign count_event = option_cfg.assign_wdt ? src_pulse
                       : presc_tc;

  // Counter mode holds an event until the next phase-two/four sample
  always_ff @(posedge clock) begin
    if (rst || wr_count || !option_cfg.src_sel) begin
      pending <= 1'b0;
    end else if (sample_phase) begin
      pending <= 1'b0;
    end else if (count_event) begin
      pending <= 1'b1;
    end
  end

  assign cnt_inc = !sleep_mode && inhibit == 4'h0 && !wr_count
                   && (option_cfg.src_sel
                       ? (sample_phase && (pending || count_event))
                       : count_event);

  // Post-write inhibit window, two instruction cycles long
  always_ff @(posedge clock) begin
    if (rst) begin
      inhibit <= 4'h0;
    end else if (wr_count) begin
      inhibit <= timer_defs::INHIBIT_CLOCKS;
    end else if (inhibit != 4'h0) begin
      inhibit <= inhibit - 4'h1;
    end
  end

  // Count register: writes win, sleep freezes
  always_ff @(posedge clock) begin
    if (rst) begin
      count_register <= timer_defs::COUNT_RESET;
    end else if (wr_count) begin
      count_register <= hwdata[7:0];
    end else if (cnt_inc) begin
      count_register <= count_register + 8'h01;
    end
  end

  // Overflow flag: wrap sets, software write may clear, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (cnt_inc && count_register == timer_defs::COUNT_TOP) begin
        overflow_flag <= 1'b1;
      end else if (wr_intctl) begin
        overflow_flag <= hwdata[timer_defs::INTCTL_FLAG_BIT];
      end
      if (wr_intctl) begin
        overflow_irq_enable <= hwdata[timer_defs::INTCTL_EN_BIT];
      end
    end
  end

  // Interrupt request only while enabled
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && overflow_irq_enable && !unused_bits
                      || overflow_flag && overflow_irq_enable;
    end
  end

  wrap_sets_flag_a: assert property (@(posedge clock) disable iff (rst)
    cnt_inc && count_register == timer_defs::COUNT_TOP
    |=> overflow_flag && count_register == 8'h00)
    else $error("wrap did not set flag");
  flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
    overflow_flag && !wr_intctl |=> overflow_flag)
    else $error("flag cleared by hardware");
  irq_gating_a: assert property (@(posedge clock) disable iff (rst)
    ##1 overflow_irq == $past(overflow_flag && overflow_irq_enable))
    else $error("irq does not follow flag and enable");
  write_inhibit_a: assert property (@(posedge clock) disable iff (rst)
    wr_count |=> (!cnt_inc) [*8])
    else $error("count advanced inside inhibit window");
  inhibit_ends_a: assert property (@(posedge clock) disable iff (rst)
    wr_count ##1 (!wr_count) [*8] |=> inhibit == 4'h0)
    else $error("inhibit window too long");
  sleep_freeze_a: assert property (@(posedge clock) disable iff (rst)
    sleep_mode && !wr_count |=> count_register == $past(count_register))
    else $error("count moved in sleep");
  timer_undivided_a: assert property (@(posedge clock) disable iff (rst)
    !option_cfg.src_sel && option_cfg.assign_wdt && instr_tick
    && !sleep_mode && inhibit == 4'h0 && !wr_count |-> cnt_inc)
    else $error("undivided timer missed a cycle");
  counter_sample_a: assert property (@(posedge clock) disable iff (rst)
    cnt_inc && option_cfg.src_sel |-> sample_phase)
    else $error("counter advanced off phase two/four");
  read_quiet_a: assert property (@(posedge clock) disable iff (rst)
    addr_take && !hwrite && !cnt_inc && !wr_count
    |=> count_register == $past(count_register))
    else $error("read disturbed the count");
endmodule // timer8

`default_nettype wire

// [count_source_model.sv]
// Model of the external count source driving the count input pin.
// Assumes the caller runs its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module count_source_model #(
  parameter int HOLD = 8
) (
  input wire logic clock,
  output logic pin
);
  // Line idles low between bursts
  initial pin = 1'b0;

  // Set a level, hold it long enough for phase sampling
  task automatic level(input logic v);
    pin <= v;
    repeat (HOLD) @(posedge clock);
  endtask

  // Full low-high-low pulses
  task automatic burst(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule // count_source_model

`default_nettype wire

// [tb_timer8.sv]
// Testbench for the 8-bit timer: register access and counting checks.
// Assumes timer8, the timer_defs package and count_source_model.
`timescale 1ns/1ps
`default_nettype none

module tb_timer8;
  localparam logic [7:0] OPT = timer_defs::OFS_OPTION;
  localparam logic [7:0] CNT = timer_defs::OFS_COUNT;
  localparam logic [7:0] ICT = timer_defs::OFS_INTCTL;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic watchdog_clear = 1'b0;
  logic watchdog_tick = 1'b0;
  wire logic hreadyout, hresp, watchdog_prescaled_tick, overflow_irq, ext_pin;
  wire logic [31:0] hrdata;
  int err_count = 0;
  int num_checks = 0;
  int wd_out = 0;
  int base;
  logic [31:0] q, v;

  // Clock at 20 MHz
  always #25 clock = ~clock;
  // Counts divided watchdog pulses
  always @(posedge clock) if (watchdog_prescaled_tick === 1'b1) wd_out++;

  timer8 i_timer8 (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .external_count_input(ext_pin), .sleep_mode, .watchdog_clear,
    .watchdog_tick, .watchdog_prescaled_tick, .overflow_irq);
  count_source_model i_count_source_model (.clock, .pin(ext_pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= timer_defs::HTRANS_NONSEQ_BIT;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Count gained between two reads p clocks apart
  task automatic gap(input int p, input logic [7:0] e);
    bus(1'b0, CNT, 32'h0);
    v = q;
    idle(p - 2);
    bus(1'b0, CNT, 32'h0);
    chk({24'h0, q[7:0] - v[7:0]}, {24'h0, e});
  endtask

  // Watchdog base ticks, two clocks apart
  task automatic wd(input int n);
    repeat (n) begin
      watchdog_tick <= 1'b1;
      idle(1);
      watchdog_tick <= 1'b0;
      idle(1);
    end
    idle(3);
  endtask

  task automatic wclr();
    watchdog_clear <= 1'b1;
    idle(1);
    watchdog_clear <= 1'b0;
    idle(1);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    idle(60000);
    err_count++;
    end_of_test();
  end

  initial begin
    idle(2);
    rst <= 1'b0;
    idle(1);
    // Reset values, unmapped place, read-back
    rd(OPT, timer_defs::OPTION_RESET);
    rd(CNT, timer_defs::COUNT_RESET);
    rd(ICT, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    wr(OPT, 8'h5A);
    rd(OPT, 8'h5A);
    wr(ICT, 8'hFF);
    rd(ICT, 8'h24);
    chk({31'h0, overflow_irq}, 32'h1);
    wr(ICT, 8'h00);
    // Timer mode undivided; reads leave the count alone
    wr(OPT, 8'hC8);
    gap(40, 8'd10);
    wr(CNT, 8'h10);
    idle(5);
    rd(CNT, 8'h10);
    // Timer prescale ratios 1:2 to 1:256
    wclr();
    for (int r = 0; r < 8; r++) begin
      wr(OPT, 8'hC0 | 8'(r));
      wr(CNT, 8'h00);
      idle(10);
      gap(16 << r, 8'd2);
    end
    base = wd_out;
    wd(8);
    chk(32'(wd_out - base), 32'd0);
    // Count write restarts the hidden prescale count
    wr(CNT, 8'h00);
    idle(600);
    wr(CNT, 8'h05);
    idle(600);
    rd(CNT, 8'h05);
    idle(500);
    rd(CNT, 8'h06);
    // Hand prescaler to the watchdog
    wclr();
    wr(CNT, 8'h00);
    wr(OPT, 8'hC8);
    wclr();
    base = wd_out;
    wd(3);
    chk(32'(wd_out - base), 32'd3);
    wr(OPT, 8'hCB);
    wclr();
    base = wd_out;
    wd(7);
    chk(32'(wd_out - base), 32'd0);
    wd(1);
    chk(32'(wd_out - base), 32'd1);
    wd(4);
    wclr();
    wd(7);
    chk(32'(wd_out - base), 32'd1);
    wd(1);
    chk(32'(wd_out - base), 32'd2);
    // Wrap sets the flag; it stays until software clears it
    wr(CNT, 8'hFE);
    idle(24);
    rd(ICT, 8'h04);
    chk({31'h0, overflow_irq}, 32'h0);
    idle(40);
    rd(ICT, 8'h04);
    wr(ICT, 8'h20);
    wr(CNT, 8'hFE);
    idle(24);
    chk({31'h0, overflow_irq}, 32'h1);
    wr(ICT, 8'h20);
    idle(2);
    chk({31'h0, overflow_irq}, 32'h0);
    // Sleep freezes the count
    sleep_mode <= 1'b1;
    wr(CNT, 8'hFE);
    idle(60);
    rd(CNT, 8'hFE);
    rd(ICT, 8'h20);
    sleep_mode <= 1'b0;
    // External edges of both polarities
    for (int e = 0; e < 2; e++) begin
      wr(OPT, 8'hE8 | 8'(e << 4));
      wr(CNT, 8'h00);
      idle(10);
      i_count_source_model.level(1'b1);
      rd(CNT, (e != 0) ? 8'h00 : 8'h01);
      i_count_source_model.level(1'b0);
      rd(CNT, 8'h01);
      i_count_source_model.burst(2);
      rd(CNT, 8'h03);
    end
    // Counter mode through a timer-owned 1:2 prescaler
    wr(OPT, 8'hE0);
    wr(CNT, 8'h00);
    idle(10);
    i_count_source_model.burst(4);
    rd(CNT, 8'h02);
    end_of_test();
  end
endmodule // tb_timer8

`default_nettype wire
